// ---- inc/counter16_pkg.sv ----
package counter16_pkg;
	// Register byte addresses
	localparam logic [4:0] ADDR_TCON  = 5'h00;
	localparam logic [4:0] ADDR_GCON  = 5'h04;
	localparam logic [4:0] ADDR_CNT_L = 5'h08;
	localparam logic [4:0] ADDR_CNT_H = 5'h0c;
	localparam logic [4:0] ADDR_FLAGS = 5'h10;
	localparam logic [4:0] ADDR_IE    = 5'h14;
	localparam logic [4:0] ADDR_CCP   = 5'h18;
	localparam logic [4:0] ADDR_OPT   = 5'h1c;
	// timer_control_reg fields
	localparam int TC_ON   = 0;
	localparam int TC_SYNC = 2;
	localparam int TC_PS   = 4;
	localparam int TC_CS   = 6;
	// gate_control_reg fields
	localparam int GC_SS   = 0;
	localparam int GC_VAL  = 2;
	localparam int GC_GO   = 3;
	localparam int GC_SPM  = 4;
	localparam int GC_TM   = 5;
	localparam int GC_POL  = 6;
	localparam int GC_GE   = 7;
	// Flag, enable and option fields
	localparam int FL_OVF  = 0;
	localparam int FL_GEV  = 1;
	localparam int IE_OVF  = 0;
	localparam int IE_GEV  = 1;
	localparam int IE_PER  = 2;
	localparam int IE_GLB  = 3;
	localparam int OP_SA   = 0;
	localparam int OP_SB   = 1;
	// Clock and gate source codes
	localparam logic [1:0] CS_INSTR = 2'h0;
	localparam logic [1:0] CS_SYS   = 2'h1;
	localparam logic [1:0] CS_PIN   = 2'h2;
	localparam logic [1:0] CS_LF    = 2'h3;
	localparam logic [1:0] GS_PIN   = 2'h0;
	localparam logic [1:0] GS_T0    = 2'h1;
	localparam logic [1:0] GS_CA    = 2'h2;
	localparam logic [1:0] GS_CB    = 2'h3;
	// Divider counts and constant values
	localparam logic [1:0]  INSTR_DIV_LAST = 2'h3;
	localparam logic [7:0]  LF_DIV_LAST    = 8'h1f;
	localparam logic [7:0]  T0_TOP         = 8'hff;
	localparam logic [7:0]  T0_WRAP        = 8'h00;
	localparam logic [15:0] CNT_TOP        = 16'hffff;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	typedef enum logic [2:0] {
		SP_IDLE  = 3'b001,
		SP_ARMED = 3'b010,
		SP_WIN   = 3'b100
	} sp_state_t;
endpackage

// ---- logic/gated_counter16.sv ----
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
module gated_counter16
	import counter16_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        count_clock,
	input  wire logic        gate_input_pin,
	input  wire logic        comparator_a_output,
	input  wire logic        comparator_b_output,
	input  wire logic [7:0]  companion_timer_count,
	input  wire logic        sleep,
	input  wire logic        capture_event,
	output logic             compare_match,
	output logic             overflow_irq,
	output logic             gate_event_irq,
	output logic             wake_pulse
);
	logic [3:0]  s1_q, s2_q, s3_q, lvl_q;
	logic [1:0]  css_q, ckps_q;
	logic        on_q, sync_dis_q;
	logic        ge_q, pol_q, tm_q, spm_q;
	logic [1:0]  gss_q;
	sp_state_t   sp_q;
	logic        ovf_q, gev_q;
	logic [3:0]  ie_q;
	logic [1:0]  opt_q;
	logic [15:0] cnt_q, ccp_q;
	logic [2:0]  pre_q;
	logic [1:0]  idiv_q;
	logic [7:0]  lfdiv_q;
	logic        ext_pend_q, ca_q, cb_q, t0_prev_q;
	logic [7:0]  t0_last_q;
	logic        gp_q, tff_q, gt_q, glv_q, cmp_q;
	logic [4:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        aw_q, w_q;
	logic        instr_en, lf_en, agree_clk, ext_rise, ext_tick;
	logic        tick, pre_done, inc, cnt_wr, gate_raw, g_pol, g_t;
	logic        gate_ctl, count_en, ovf_evt, gev_evt, do_wr;
	logic [2:0]  pre_mask;
	logic [31:0] rd_d;
	logic        rd_hit;

	// Three-stage pin capture; a level counts once stages two and three agree
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s1_q  <= 4'h0;
			s2_q  <= 4'h0;
			s3_q  <= 4'h0;
			lvl_q <= 4'h0;
		end
		else
		begin
			s1_q  <= {comparator_b_output, comparator_a_output, gate_input_pin, count_clock};
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
		end
	end

	assign agree_clk = ~(s2_q[0] ^ s3_q[0]);
	assign ext_rise  = agree_clk & s3_q[0] & ~lvl_q[0];

	// Instruction-rate and low-frequency enables from dividers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			idiv_q  <= 2'h0;
			lfdiv_q <= 8'h00;
		end
		else
		begin
			idiv_q  <= idiv_q + 2'h1;
			lfdiv_q <= (lfdiv_q == LF_DIV_LAST) ? 8'h00 : lfdiv_q + 8'h01;
		end
	end

	assign instr_en = (idiv_q == INSTR_DIV_LAST);
	assign lf_en    = (lfdiv_q == LF_DIV_LAST);

	// Synchronous mode parks a pin edge until the next phase slot; toggling the
	// mode mid-flight can drop one pending edge
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ext_pend_q <= 1'b0;
		else if (sync_dis_q)
			ext_pend_q <= 1'b0;
		else if (ext_rise)
			ext_pend_q <= 1'b1;
		else if (instr_en)
			ext_pend_q <= 1'b0;
	end

	assign ext_tick = sync_dis_q ? ext_rise : (ext_pend_q & instr_en);

	// Count clock source; sleep leaves only the unsynchronised pin path alive
	always_comb
	begin
		unique case (css_q)
			CS_INSTR: tick = instr_en;
			CS_SYS:   tick = 1'b1;
			CS_PIN:   tick = ext_tick;
			CS_LF:    tick = lf_en;
		endcase
		if (sleep && !(css_q == CS_PIN && sync_dis_q))
			tick = 1'b0;
	end

	assign pre_mask = 3'((4'h1 << ckps_q) - 4'h1);
	assign pre_done = (pre_q == pre_mask);

	// Comparator levels re-timed on the count clock when their option is set
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ca_q <= 1'b0;
			cb_q <= 1'b0;
		end
		else if (tick)
		begin
			ca_q <= lvl_q[2];
			cb_q <= lvl_q[3];
		end
	end

	// Companion timer wrap detector
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			t0_last_q <= 8'h00;
			t0_prev_q <= 1'b0;
		end
		else
		begin
			t0_last_q <= companion_timer_count;
			t0_prev_q <= 1'b1;
		end
	end

	// Gate source select
	always_comb
	begin
		unique case (gss_q)
			GS_PIN: gate_raw = lvl_q[1];
			GS_T0:  gate_raw = t0_prev_q && t0_last_q == T0_TOP
			                   && companion_timer_count == T0_WRAP;
			GS_CA:  gate_raw = opt_q[OP_SA] ? ca_q : lvl_q[2];
			GS_CB:  gate_raw = opt_q[OP_SB] ? cb_q : lvl_q[3];
		endcase
	end

	assign g_pol = pol_q ? gate_raw : ~gate_raw;
	assign g_t   = tm_q ? tff_q : g_pol;

	// Toggle flip-flop; held clear so the measured edge is known at enable
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			gp_q  <= 1'b0;
			tff_q <= 1'b0;
		end
		else
		begin
			gp_q <= g_pol;
			if (!tm_q || !on_q)
				tff_q <= 1'b0;
			else if (g_pol && !gp_q)
				tff_q <= ~tff_q;
		end
	end

	// Single-pulse window follows the (possibly toggled) gate
	assign gate_ctl = spm_q ? (sp_q == SP_WIN) : g_t;
	assign count_en = on_q && (!ge_q || gate_ctl);
	assign cnt_wr   = do_wr && (awaddr_q == ADDR_CNT_L || awaddr_q == ADDR_CNT_H) && wstrb_q[0];
	assign inc      = count_en && tick && pre_done && !cnt_wr;
	assign ovf_evt  = inc && (cnt_q == CNT_TOP);
	assign gev_evt  = glv_q && !gate_ctl;
	assign do_wr    = aw_q && w_q && !s_axi_bvalid;

	// Prescaler; a count byte write restarts it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pre_q <= 3'h0;
		else if (cnt_wr || !on_q)
			pre_q <= 3'h0;
		else if (tick && count_en)
			pre_q <= pre_done ? 3'h0 : pre_q + 3'h1;
	end

	// Counter; a byte write wins over an increment in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_q <= 16'h0000;
		else if (cnt_wr)
		begin
			if (awaddr_q == ADDR_CNT_L)
				cnt_q[7:0] <= wdata_q[7:0];
			else
				cnt_q[15:8] <= wdata_q[7:0];
		end
		else if (inc)
			cnt_q <= cnt_q + 16'h0001;
	end

	// Gate history for edge detection
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			gt_q  <= 1'b0;
			glv_q <= 1'b0;
		end
		else
		begin
			gt_q  <= g_t;
			glv_q <= gate_ctl;
		end
	end

	// Single-pulse sequencer; software writes to go override hardware
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sp_q <= SP_IDLE;
		else if (do_wr && awaddr_q == ADDR_GCON && wstrb_q[0])
		begin
			if (!wdata_q[GC_GO])
				sp_q <= SP_IDLE;
			else if (sp_q == SP_IDLE)
				sp_q <= SP_ARMED;
		end
		else if (spm_q)
		begin
			unique case (sp_q)
				SP_IDLE:  sp_q <= SP_IDLE;
				SP_ARMED: if (g_t && !gt_q) sp_q <= SP_WIN;
				SP_WIN:   if (!g_t && gt_q) sp_q <= SP_IDLE;
				default:  sp_q <= SP_IDLE;
			endcase
		end
	end

	// Sticky flags; an event in the clearing cycle is kept
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ovf_q <= 1'b0;
			gev_q <= 1'b0;
		end
		else
		begin
			if (ovf_evt)
				ovf_q <= 1'b1;
			else if (do_wr && awaddr_q == ADDR_FLAGS && wstrb_q[0] && wdata_q[FL_OVF])
				ovf_q <= 1'b0;
			if (gev_evt)
				gev_q <= 1'b1;
			else if (do_wr && awaddr_q == ADDR_FLAGS && wstrb_q[0] && wdata_q[FL_GEV])
				gev_q <= 1'b0;
		end
	end

	assign overflow_irq   = ovf_q && on_q && ie_q[IE_OVF] && ie_q[IE_PER] && ie_q[IE_GLB];
	assign gate_event_irq = gev_q && ie_q[IE_GEV] && ie_q[IE_PER] && ie_q[IE_GLB];

	// Wake pulse registered; compare level registered for the match edge
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wake_pulse <= 1'b0;
			cmp_q      <= 1'b0;
		end
		else
		begin
			wake_pulse <= sleep && ovf_evt && ie_q[IE_OVF] && ie_q[IE_PER];
			cmp_q      <= (cnt_q == ccp_q);
		end
	end

	// Match fires once on entry, not for every cycle the count rests there
	assign compare_match = (cnt_q == ccp_q) && !cmp_q;

	// Control registers and capture pair
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			{css_q, ckps_q, sync_dis_q, on_q} <= 6'h00;
			{ge_q, pol_q, tm_q, spm_q}        <= 4'h0;
			gss_q <= 2'h0;
			ie_q  <= 4'h0;
			opt_q <= 2'h0;
			ccp_q <= 16'h0000;
		end
		else
		begin
			if (capture_event)
				ccp_q <= cnt_q;
			else if (do_wr && awaddr_q == ADDR_CCP)
			begin
				if (wstrb_q[0])
					ccp_q[7:0] <= wdata_q[7:0];
				if (wstrb_q[1])
					ccp_q[15:8] <= wdata_q[15:8];
			end
			if (do_wr && wstrb_q[0])
			begin
				unique case (awaddr_q)
					ADDR_TCON:
					begin
						css_q      <= wdata_q[TC_CS +: 2];
						ckps_q     <= wdata_q[TC_PS +: 2];
						sync_dis_q <= wdata_q[TC_SYNC];
						on_q       <= wdata_q[TC_ON];
					end
					ADDR_GCON:
					begin
						ge_q  <= wdata_q[GC_GE];
						pol_q <= wdata_q[GC_POL];
						tm_q  <= wdata_q[GC_TM];
						spm_q <= wdata_q[GC_SPM];
						gss_q <= wdata_q[GC_SS +: 2];
					end
					ADDR_IE:  ie_q  <= wdata_q[3:0];
					ADDR_OPT: opt_q <= wdata_q[1:0];
					default:  ;
				endcase
			end
		end
	end

	// Write channel: address and data taken in either order, then one response
	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_q && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_q         <= 1'b0;
			w_q          <= 1'b0;
			awaddr_q     <= 5'h00;
			wdata_q      <= 32'h0;
			wstrb_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_q     <= 1'b1;
				awaddr_q <= {s_axi_awaddr[4:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_q     <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_wr)
			begin
				aw_q         <= 1'b0;
				w_q          <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q == ADDR_FLAGS || awaddr_q[4:3] != 2'h3 || awaddr_q == ADDR_CCP
				                 || awaddr_q == ADDR_OPT) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read mux; all state is in the bus clock so a byte read is never torn
	always_comb
	begin
		rd_d   = 32'h0;
		rd_hit = 1'b1;
		unique case ({s_axi_araddr[4:2], 2'b00})
			ADDR_TCON:  rd_d[7:0] = {css_q, ckps_q, 1'b0, sync_dis_q, 1'b0, on_q};
			ADDR_GCON:  rd_d[7:0] = {ge_q, pol_q, tm_q, spm_q, sp_q != SP_IDLE, gate_ctl, gss_q};
			ADDR_CNT_L: rd_d[7:0] = cnt_q[7:0];
			ADDR_CNT_H: rd_d[7:0] = cnt_q[15:8];
			ADDR_FLAGS: rd_d[1:0] = {gev_q, ovf_q};
			ADDR_IE:    rd_d[3:0] = ie_q;
			ADDR_CCP:   rd_d[15:0] = ccp_q;
			ADDR_OPT:   rd_d[1:0] = opt_q;
			default:    rd_hit = 1'b0;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	// Read channel: one read in flight, answered one cycle after it is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_d;
			s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule // gated_counter16

// ---- tb/gated_counter16_monitor.sv ----
// Checks the register bus handshake and the wake pulse at the block's ports
module gated_counter16_monitor
	import counter16_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        sleep,
	input wire logic        wake_pulse,
	input wire logic        overflow_irq,
	input wire logic        gate_event_irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// A response must stand until the master takes it
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed while waiting");
	// No new request while an answer is pending
	a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	a_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_wr_okay: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OKAY)
		else $error("write response not okay");
	// Every word is mapped, so a read never answers with an error
	a_rd_okay: assert property (s_axi_rvalid |-> s_axi_rresp == RESP_OKAY)
		else $error("read response not okay");
	// Wake is a single-cycle pulse, only out of sleep
	a_wake_single: assert property (wake_pulse |=> !wake_pulse)
		else $error("wake pulse too long");
	a_wake_sleep: assert property (wake_pulse |-> $past(sleep))
		else $error("wake without sleep");

	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_wake: cover property (wake_pulse);
	c_ovf_irq: cover property (overflow_irq);
	c_gev_irq: cover property (gate_event_irq);
endmodule // gated_counter16_monitor

bind gated_counter16 gated_counter16_monitor gated_counter16_monitor_inst (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sleep(sleep), .wake_pulse(wake_pulse),
	.overflow_irq(overflow_irq), .gate_event_irq(gate_event_irq), .s_axi_rresp(s_axi_rresp)
);

// ---- tb/gated_counter16_tb.sv ----
module gated_counter16_tb
	import counter16_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rstn, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
	logic        cclk, pin, ca, cb, slp, cap, cm, oirq, girq, wake, woke;
	logic [4:0]  awa, ara;
	logic [31:0] wd, rdat, a0, a1;
	logic [7:0]  t0;
	logic [1:0]  bresp, rresp;
	logic [3:0]  ws;
	int          error_cnt, cmp_count;
	int          cm_cnt = 0;
	localparam logic [4:0] RA [7] = '{ADDR_TCON, ADDR_CNT_L, ADDR_CNT_H, ADDR_FLAGS, ADDR_IE, ADDR_CCP, ADDR_OPT};

	gated_counter16 gated_counter16_inst (
		.aclk(clk), .aresetn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .count_clock(cclk),
		.gate_input_pin(pin), .comparator_a_output(ca), .comparator_b_output(cb), .companion_timer_count(t0),
		.sleep(slp), .capture_event(cap), .compare_match(cm), .overflow_irq(oirq), .gate_event_irq(girq),
		.wake_pulse(wake)
	);

	initial
	begin
		clk = 0;
		forever #50 clk = ~clk;
	end

	// Latch the one-cycle wake pulse so a later compare cannot miss it
	always @(posedge clk)
		if (wake === 1'b1)
			woke <= 1;

	// Count compare pulses at the edge so a one-cycle pulse is never missed
	always @(posedge clk)
		if (cm === 1'b1)
			cm_cnt <= cm_cnt + 1;

	task automatic report_and_stop;
		$display("errors=%0d compares=%0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Address and data offered together; each released once taken
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		br <= 1;
		do
		begin
			@(posedge clk);
			if (awr)
				awv <= 0;
			if (wr_rdy)
				wv <= 0;
			n++;
		end while (bv !== 1'b1 && n < 50);
		br <= 0;
		if (bv !== 1'b1)
		begin
			error_cnt++;
			report_and_stop;
		end
	endtask

	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		ara <= a;
		arv <= 1;
		rr <= 1;
		do
		begin
			@(posedge clk);
			if (arr)
				arv <= 0;
			n++;
		end while (rv !== 1'b1 && n < 50);
		d = rdat;
		rr <= 0;
		if (rv !== 1'b1)
		begin
			error_cnt++;
			report_and_stop;
		end
	endtask

	task automatic rc(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] g;
		rd(a, g);
		chk(g, e);
	endtask

	// Selected gate source gets v, the others the opposite, to prove selection
	task automatic drv(input logic [1:0] s, input logic v);
		pin <= (s == GS_PIN) ? v : !v;
		ca <= (s == GS_CA) ? v : !v;
		cb <= (s == GS_CB) ? v : !v;
		repeat (8) @(posedge clk);
	endtask

	// Hang guard
	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		report_and_stop;
	end

	initial
	begin
		{awv, wv, br, arv, rr, cclk, pin, ca, cb, slp, cap, woke} = '0;
		awa = '0;
		ara = '0;
		wd = '0;
		ws = 4'hf;
		t0 = 8'h00;
		rstn = 0;
		error_cnt = 0;
		cmp_count = 0;
		repeat (2) @(posedge clk);
		rstn <= 1;
		foreach (RA[i])
			rc(RA[i], 32'h0);
		// Load and capture while stopped
		wr(ADDR_CNT_L, 32'h34);
		wr(ADDR_CNT_H, 32'h12);
		rc(ADDR_CNT_L, 32'h34);
		rc(ADDR_CNT_H, 32'h12);
		a1 = 32'(cm_cnt);
		cap <= 1;
		@(posedge clk);
		cap <= 0;
		rc(ADDR_CCP, 32'h1234);
		chk(32'(cm_cnt) - a1, 32'h1);
		// Rollover with all enables set
		wr(ADDR_CNT_L, 32'hff);
		wr(ADDR_CNT_H, 32'hff);
		wr(ADDR_IE, 32'hf);
		wr(ADDR_TCON, 32'({CS_SYS, 6'h01}));
		rd(ADDR_FLAGS, a0);
		chk(a0 & 32'h1, 32'h1);
		chk(oirq, 32'h1);
		wr(ADDR_TCON, 32'h0);
		chk(oirq, 32'h0);
		rd(ADDR_CNT_L, a0);
		rc(ADDR_CNT_L, a0);
		wr(ADDR_FLAGS, 32'h3);
		rc(ADDR_FLAGS, 32'h0);
		// Gated counting, active-high gate on the pin
		wr(ADDR_CNT_L, 32'h0);
		wr(ADDR_CNT_H, 32'h0);
		wr(ADDR_GCON, 32'hc0);
		drv(GS_PIN, 0);
		wr(ADDR_TCON, 32'({CS_SYS, 6'h01}));
		rc(ADDR_CNT_L, 32'h0);
		drv(GS_PIN, 1);
		rc(ADDR_GCON, 32'hc4);
		rd(ADDR_CNT_L, a0);
		chk(32'(a0 != 0), 32'h1);
		drv(GS_PIN, 0);
		rd(ADDR_CNT_L, a0);
		rc(ADDR_CNT_L, a0);
		rd(ADDR_FLAGS, a1);
		chk(a1 & 32'h2, 32'h2);
		chk(girq, 32'h1);
		// Level status per source except the companion timer, with gating off
		for (int s = 0; s < 4; s++)
			if (s != 1)
			begin
				wr(ADDR_GCON, 32'h40 | s);
				drv(2'(s), 1);
				rd(ADDR_GCON, a0);
				chk(a0 & 32'h4, 32'h4);
				drv(2'(s), 0);
				rd(ADDR_GCON, a0);
				chk(a0 & 32'h4, 32'h0);
			end
		// Companion wrap gives a gate pulse, seen as a gate event
		wr(ADDR_FLAGS, 32'h3);
		wr(ADDR_GCON, 32'h41);
		t0 <= T0_TOP;
		@(posedge clk);
		t0 <= T0_WRAP;
		repeat (8) @(posedge clk);
		rd(ADDR_FLAGS, a0);
		chk(a0 & 32'h2, 32'h2);
		// One pulse counted, the next ignored
		drv(GS_PIN, 0);
		wr(ADDR_GCON, 32'hd8);
		rd(ADDR_CNT_L, a0);
		drv(GS_PIN, 1);
		drv(GS_PIN, 0);
		rc(ADDR_GCON, 32'hd0);
		rd(ADDR_CNT_L, a1);
		chk(32'(a1 != a0), 32'h1);
		drv(GS_PIN, 1);
		drv(GS_PIN, 0);
		rc(ADDR_CNT_L, a1);
		// Toggle mode keeps the gate open after the pin falls
		wr(ADDR_GCON, 32'he0);
		drv(GS_PIN, 1);
		drv(GS_PIN, 0);
		rc(ADDR_GCON, 32'he4);
		wr(ADDR_GCON, 32'hc0);
		rc(ADDR_GCON, 32'hc0);
		// Re-enabled toggle must start from a cleared flip-flop
		wr(ADDR_GCON, 32'he0);
		rc(ADDR_GCON, 32'he0);
		// Unsynchronised pin counting in sleep wakes on rollover
		wr(ADDR_TCON, 32'h0);
		wr(ADDR_CNT_L, 32'hfe);
		wr(ADDR_CNT_H, 32'hff);
		wr(ADDR_GCON, 32'h0);
		wr(ADDR_TCON, 32'({CS_PIN, 6'h05}));
		slp <= 1;
		repeat (3)
		begin
			cclk <= 1;
			repeat (4) @(posedge clk);
			cclk <= 0;
			repeat (4) @(posedge clk);
		end
		chk(woke, 32'h1);
		slp <= 0;
		// Synced comparator A only follows on a count tick
		wr(ADDR_OPT, 32'h1);
		wr(ADDR_GCON, 32'h42);
		drv(GS_CA, 0);
		rd(ADDR_GCON, a0);
		chk(a0 & 32'h4, 32'h4);
		cclk <= 1;
		repeat (4) @(posedge clk);
		cclk <= 0;
		rc(ADDR_GCON, 32'h42);
		report_and_stop;
	end
endmodule // gated_counter16_tb
